/* File: verilog/mtwc_position.sv */
// Top of the multi-turn wrap position counter with home offset presets
`timescale 1ns/1ps
`default_nettype none
module mtwc_position
   import mtwc_pkg::*;
(
   // Clock and reset
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   // Configuration
   input  wire logic [2:0]          i_encoder_usage_select,
   input  wire logic [15:0]         i_multiturn_upper_limit,
   input  wire logic                i_full_closed,
   // Encoder single-turn data
   input  wire logic                i_st_valid,
   input  wire logic [ST_BITS-1:0]  i_st_pos,
   // Preset events
   input  wire logic                i_homing_run_done,
   input  wire logic                i_init_to_preop,
   input  wire logic                i_multiturn_clear,
   input  wire logic                i_tool_done,
   // Register port
   input  wire logic                i_reg_wr,
   input  wire logic [15:0]         i_reg_addr,
   input  wire logic [31:0]         i_reg_wdata,
   output var  logic [31:0]         o_reg_rdata,
   // Position
   output var  logic [ST_BITS-1:0]  o_single_turn,
   output logic      [MT_BITS-1:0]  o_multiturn,
   output var  logic [POS_BITS-1:0] o_actual_pos
);
   mtwc_mode_type           mode;
   logic [15:0]             limit;
   logic                    step_up;
   logic                    step_dn;
   logic                    preset_hit;
   logic [RAW_BITS-1:0]     raw;
   logic signed [SUM_BITS-1:0] span;
   logic signed [SUM_BITS-1:0] sum;

   logic [31:0]             home_position_offset;
   logic [31:0]             next_home_position_offset;
   logic [31:0]             bias;
   logic [31:0]             next_bias;
   logic                    power_on;
   logic [ST_BITS-1:0]      next_single_turn;
   logic [POS_BITS-1:0]     next_actual_pos;
   logic [31:0]             next_reg_rdata;
   logic                    have_sample;
   logic                    next_have_sample;

   // ==========================================================================
   // Mode and limit decode
   always_comb
   begin
      if (i_full_closed)
         mode = MTWC_INC;
      else
         mode = mtwc_mode_type'(i_encoder_usage_select);
      if (mode == MTWC_CONTINUOUS)
      begin
         if (i_multiturn_upper_limit == 16'h0000)
            limit = MT_LIMIT_MIN;
         else if (i_multiturn_upper_limit > MT_LIMIT_MAX)
            limit = MT_LIMIT_MAX;
         else
            limit = i_multiturn_upper_limit;
      end
      else
         limit = MT_FIXED_LIMIT;
   end

   // ==========================================================================
   // Rollover detection on quarter crossings
   // Encoder must move less than a quarter turn per sample.
   // First sample after reset only seeds the previous value; the reset
   // value of the single-turn register would otherwise fake a rollover.
   always_comb
   begin
      next_have_sample = have_sample || i_st_valid;
      step_up = have_sample && i_st_valid
                && (o_single_turn[ST_BITS-1 -: 2] == ST_TOP_QUARTER)
                && (i_st_pos[ST_BITS-1 -: 2] == ST_LOW_QUARTER);
      step_dn = have_sample && i_st_valid
                && (o_single_turn[ST_BITS-1 -: 2] == ST_LOW_QUARTER)
                && (i_st_pos[ST_BITS-1 -: 2] == ST_TOP_QUARTER);
   end

   // Single-turn mode keeps no turn count; same counter serves all loops
   mtwc_turn_counter #(
      .WIDTH   (MT_BITS)
   ) u_turns (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_step_up (step_up),
      .i_step_dn (step_dn),
      .i_clear   (i_multiturn_clear || (mode == MTWC_SINGLE)),
      .i_limit   (limit),
      .o_count   (o_multiturn)
   );

   // ==========================================================================
   // Actual position with wrap
   // One fold suffices while offset and count stay inside one span.
   always_comb
   begin
      raw  = {o_multiturn, o_single_turn};
      span = SUM_BITS'({24'h00_0000, limit} + 40'h1) <<< ST_BITS;
      sum  = $signed({1'b0, raw}) + SUM_BITS'($signed(bias));
      if (mode == MTWC_CONTINUOUS)
      begin
         if (sum < 0)
            sum = sum + span;
         else if (sum >= span)
            sum = sum - span;
      end
      next_actual_pos  = sum[POS_BITS-1:0];
      next_single_turn = i_st_valid ? i_st_pos : o_single_turn;
   end

   // ==========================================================================
   // Home offset register and presets
   always_comb
   begin
      preset_hit = power_on || i_init_to_preop || i_multiturn_clear || i_tool_done;
      next_home_position_offset = home_position_offset;
      if (i_reg_wr && (i_reg_addr == HOME_OFFSET_ADR))
         next_home_position_offset = i_reg_wdata;
      next_bias = bias;
      if (i_homing_run_done)
         next_bias = home_position_offset - raw[31:0];
      else if (preset_hit)
         next_bias = home_position_offset;
   end

   // ==========================================================================
   // Register read-back
   // Address-only read: data follows the address one cycle later, no strobe.
   always_comb
   begin
      if (i_reg_addr == HOME_OFFSET_ADR)
         next_reg_rdata = home_position_offset;
      else
         next_reg_rdata = 32'h0000_0000;
   end

   // Power-on preset runs on the first edge after reset release
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         home_position_offset <= HOME_OFFSET_RST;
         bias                 <= 32'h0000_0000;
         power_on             <= 1'b1;
         have_sample          <= 1'b0;
         o_single_turn        <= '0;
         o_actual_pos         <= '0;
         o_reg_rdata          <= 32'h0000_0000;
      end
      else
      begin
         home_position_offset <= next_home_position_offset;
         bias                 <= next_bias;
         power_on             <= 1'b0;
         have_sample          <= next_have_sample;
         o_single_turn        <= next_single_turn;
         o_actual_pos         <= next_actual_pos;
         o_reg_rdata          <= next_reg_rdata;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   wrap_up_a: assert property (step_up && !i_multiturn_clear
      && mode == MTWC_CONTINUOUS && o_multiturn >= limit |=> o_multiturn == 16'h0000)
      else $error("turn count did not wrap to zero");
   wrap_down_a: assert property (step_dn && !i_multiturn_clear
      && mode == MTWC_CONTINUOUS && o_multiturn == 16'h0000 |=> o_multiturn == $past(limit))
      else $error("turn count did not load upper limit");
   fixed_limit_a: assert property ((mode == MTWC_ABS || mode == MTWC_ABS_NOOVF)
      |-> limit == MT_FIXED_LIMIT)
      else $error("absolute mode limit not 65535");
   inc_limit_a: assert property ((mode == MTWC_INC || mode == MTWC_SINGLE)
      |-> limit == MT_FIXED_LIMIT)
      else $error("programmed limit used outside continuous mode");
   zero_limit_a: assert property (mode == MTWC_CONTINUOUS
      && i_multiturn_upper_limit == 16'h0000 |-> limit == MT_LIMIT_MIN)
      else $error("limit zero not treated as one");
   closed_loop_a: assert property (i_full_closed |-> mode == MTWC_INC)
      else $error("full-closed not incremental");
   single_zero_a: assert property (mode == MTWC_SINGLE |=> o_multiturn == 16'h0000)
      else $error("single-turn mode kept a turn count");
   homing_a: assert property (i_homing_run_done
      |=> bias + $past(raw[31:0]) == $past(home_position_offset))
      else $error("homing offset not applied");
   preset_a: assert property (!i_homing_run_done && (i_init_to_preop || i_tool_done)
      |=> bias == $past(home_position_offset))
      else $error("preset did not load home offset");
   clear_a: assert property (!i_homing_run_done && i_multiturn_clear
      |=> o_multiturn == 16'h0000 && bias == $past(home_position_offset))
      else $error("turn clear did not preset position");
   pos_range_a: assert property (mode == MTWC_CONTINUOUS |-> sum >= 0 && sum < span)
      else $error("actual position outside wrap span");
   count_up_a: assert property (step_up && !i_multiturn_clear && mode != MTWC_SINGLE
      && o_multiturn < limit |=> o_multiturn == $past(o_multiturn) + 16'h0001)
      else $error("turn count missed positive rollover");
   count_down_a: assert property (step_dn && !i_multiturn_clear && mode != MTWC_SINGLE
      && o_multiturn != 16'h0000 |=> o_multiturn == $past(o_multiturn) - 16'h0001)
      else $error("turn count missed negative rollover");
   first_sample_a: assert property (i_st_valid && !have_sample
      |-> !step_up && !step_dn)
      else $error("first sample after reset stepped the turn count");

   wrap_c: cover property (step_up && mode == MTWC_CONTINUOUS && o_multiturn == limit);
   under_c: cover property (step_dn && mode == MTWC_CONTINUOUS && o_multiturn == 16'h0000);
   homing_c: cover property (i_homing_run_done);
   seed_c: cover property (i_st_valid && !have_sample);
   write_c: cover property (i_reg_wr && i_reg_addr == HOME_OFFSET_ADR ##1 i_init_to_preop);
endmodule : mtwc_position
`default_nettype wire

/* File: verilog/mtwc_pkg.sv */
// Constants and types for the multi-turn wrap position counter
// ==========================================================================
// How it works
// - Usage setting 0..4 selects counter mode
// - Wrap count to zero above upper limit
// - Below zero loads count with upper limit
// - Modes 0 and 2 use limit 65535
// - Modes 1 and 3 ignore programmed limit
// - Limit 0 behaves as limit 1
// - Full-closed control forces incremental mode
// - Homing makes index position equal offset
// - Presets add home offset to position
// - Wrapping at the programmed limit works in mode 4 only, so not under full-closed control
// - Actual position wraps with turn count in mode 4 only
// ==========================================================================
package mtwc_pkg;
   localparam int             ST_BITS         = 23;
   localparam int             MT_BITS         = 16;
   localparam int             POS_BITS        = 32;
   localparam int             RAW_BITS        = ST_BITS + MT_BITS;
   localparam int             SUM_BITS        = RAW_BITS + 1;
   localparam logic [15:0]    HOME_OFFSET_ADR = 16'h607c;
   localparam logic [31:0]    HOME_OFFSET_RST = 32'h0000_0000;
   localparam logic [15:0]    MT_FIXED_LIMIT  = 16'hffff;
   localparam logic [15:0]    MT_LIMIT_MAX    = 16'hfffe;
   localparam logic [15:0]    MT_LIMIT_MIN    = 16'h0001;
   localparam logic [1:0]     ST_TOP_QUARTER  = 2'h3;
   localparam logic [1:0]     ST_LOW_QUARTER  = 2'h0;

   typedef enum logic [2:0]
   {
      MTWC_ABS        = 3'h0,
      MTWC_INC        = 3'h1,
      MTWC_ABS_NOOVF  = 3'h2,
      MTWC_SINGLE     = 3'h3,
      MTWC_CONTINUOUS = 3'h4
   } mtwc_mode_type;
endpackage : mtwc_pkg

/* File: verilog/mtwc_turn_counter.sv */
// Multi-turn count with programmable wrap in both directions
`timescale 1ns/1ps
`default_nettype none
module mtwc_turn_counter
   import mtwc_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   // Control
   input  wire logic             i_step_up,
   input  wire logic             i_step_dn,
   input  wire logic             i_clear,
   input  wire logic [WIDTH-1:0] i_limit,
   // Count
   output var  logic [WIDTH-1:0] o_count
);
   logic [WIDTH-1:0] next_count;

   // ==========================================================================
   // Count update
   always_comb
   begin
      next_count = o_count;
      if (i_clear)
      begin
         next_count = '0;
      end
      else if (i_step_up)
      begin
         if (o_count >= i_limit)
            next_count = '0;
         else
            next_count = o_count + 1'b1;
      end
      else if (i_step_dn)
      begin
         if (o_count == '0)
            next_count = i_limit;
         else
            next_count = o_count - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_count <= '0;
      else
         o_count <= next_count;
   end
endmodule : mtwc_turn_counter
`default_nettype wire

/* File: verification/mtwc_enc_model.sv */
// Behavioural absolute encoder that feeds single-turn samples
`timescale 1ns/1ps
`default_nettype none
module mtwc_enc_model
   import mtwc_pkg::*;
#(
   parameter logic [ST_BITS-1:0] START = 23'h012345,
   parameter logic [ST_BITS-1:0] STEP  = 23'h100000
)
(
   // Clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   // Motion control
   input  wire logic               i_run,
   input  wire logic               i_up,
   // Sample word
   output var  logic               o_st_valid,
   output var  logic [ST_BITS-1:0] o_st_pos
);
   // ======================================================================
   // Sample generation
   logic [ST_BITS-1:0] pos;
   // Stale word is scrambled so the counter cannot lean on it
   assign o_st_pos = o_st_valid ? pos : ~pos;
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pos        <= START;
         o_st_valid <= 1'b0;
      end
      else
      begin
         o_st_valid <= i_run;
         if (i_run)
            pos <= i_up ? pos + STEP : pos - STEP;
      end
   end
endmodule : mtwc_enc_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the position counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mtwc_pkg::*;
   // ======================================================================
   // Signals
   localparam logic [22:0] STEP = 23'h100000;
   logic        ref_clk, rst_n, fc, run, up, wr, st_v;
   logic [2:0]  mode;
   logic [3:0]  ev;
   logic [15:0] lim, addr, cnt_e, mt;
   logic [31:0] wd, rd, pos, off;
   logic [22:0] st_e, st, st_p, nxt;
   int          n_errors, comparisons, seed, k;

   mtwc_enc_model #(.START(23'h0), .STEP(STEP)) mtwc_enc_model_inst (.i_ref_clk(ref_clk),
      .i_rst_n(rst_n), .i_run(run),
      .i_up(up), .o_st_valid(st_v), .o_st_pos(st_p));
   mtwc_position mtwc_position_inst (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
      .i_encoder_usage_select(mode), .i_multiturn_upper_limit(lim), .i_full_closed(fc),
      .i_st_valid(st_v), .i_st_pos(st_p), .i_homing_run_done(ev[0]),
      .i_init_to_preop(ev[1]), .i_multiturn_clear(ev[2]), .i_tool_done(ev[3]),
      .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd),
      .o_single_turn(st), .o_multiturn(mt), .o_actual_pos(pos));

   // ======================================================================
   // Expectations
   function automatic logic [15:0] eff_lim(logic [15:0] l);
      return (l == 16'h0) ? 16'h1 : ((l > MT_LIMIT_MAX) ? MT_LIMIT_MAX : l);
   endfunction : eff_lim

   function automatic logic [15:0] stepc(logic [15:0] c, logic u);
      logic [2:0] m;
      m = fc ? 3'h1 : mode;
      if (m == 3'h3)
         return 16'h0;
      if (m == 3'h4)
         return u ? ((c >= eff_lim(lim)) ? 16'h0 : c + 16'h1)
                  : ((c == 16'h0) ? eff_lim(lim) : c - 16'h1);
      return u ? c + 16'h1 : c - 16'h1;
   endfunction : stepc

   function automatic logic [31:0] exp_pos();
      logic [39:0] r;
      logic [39:0] span;
      r    = {1'b0, cnt_e, st_e} + {8'h0, off};
      span = ({24'h0, eff_lim(lim)} + 40'h1) << ST_BITS;
      if (!fc && mode == 3'h4 && r >= span)
         r = r - span;
      return r[31:0];
   endfunction : exp_pos

   // ======================================================================
   // Tasks
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   task automatic reg_rd(logic [15:0] a, logic [31:0] e);
      @(posedge ref_clk) addr <= a;
      repeat (2) @(posedge ref_clk);
      #1 check("rdata", rd, e);
   endtask : reg_rd

   task automatic reg_wr(logic [15:0] a, logic [31:0] d);
      @(posedge ref_clk) wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge ref_clk) wr <= 1'b0;
   endtask : reg_wr

   task automatic pulse(int i);
      @(posedge ref_clk) ev[i] <= 1'b1;
      @(posedge ref_clk) ev <= 4'h0;
      repeat (3) @(posedge ref_clk);
   endtask : pulse

   task automatic spin(int n, logic u);
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk) run <= 1'b1;
         up <= u;
         nxt = u ? st_e + STEP : st_e - STEP;
         if (u && st_e[22:21] == 2'h3 && nxt[22:21] == 2'h0)
            cnt_e = stepc(cnt_e, 1'b1);
         if (!u && st_e[22:21] == 2'h0 && nxt[22:21] == 2'h3)
            cnt_e = stepc(cnt_e, 1'b0);
         st_e = nxt;
      end
      @(posedge ref_clk) run <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : spin

   task automatic chk_all();
      #1 check("single", {9'h0, st}, {9'h0, st_e});
      check("turns", {16'h0, mt}, {16'h0, cnt_e});
      check("pos", pos, exp_pos());
   endtask : chk_all

   // ======================================================================
   // Clock, watchdog and sequence
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial
   begin
      #160000 n_errors++;
      stop_test();
   end

   initial
   begin
      {rst_n, fc, run, up, wr, mode, ev, addr, wd, off, cnt_e} = '0;
      lim = 16'h1;
      seed = 5373;
      // Encoder starts at zero, the reset value of the single-turn output
      st_e = 23'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk_all();
      reg_rd(HOME_OFFSET_ADR, HOME_OFFSET_RST);
      off = {9'h0, 23'($random(seed))};
      reg_wr(HOME_OFFSET_ADR, off);
      reg_wr(16'h1234, ~off);
      reg_rd(16'h1234, 32'h0);
      reg_rd(HOME_OFFSET_ADR, off);
      // Mode table: 0..4, then limit zero, then full-closed over mode 4
      for (k = 0; k < 7; k++)
      begin
         // Clear first: a new limit must never meet a count above it
         pulse(2);
         @(posedge ref_clk) mode <= (k < 4) ? 3'(k) : 3'h4;
         lim <= (k == 5) ? 16'h0 : 16'h1 + 16'({$random(seed)} % 3);
         fc <= (k == 6);
         pulse(2);
         cnt_e = 16'h0;
         chk_all();
         spin(8 * (int'(eff_lim(lim)) + 2), 1'b1);
         chk_all();
         spin(8 * (int'(eff_lim(lim)) + 3), 1'b0);
         chk_all();
      end
      @(posedge ref_clk) mode <= 3'h0;
      fc <= 1'b0;
      pulse(0);
      #1 check("home", pos, off);
      for (k = 1; k < 4; k++)
      begin
         spin(3, k[0]);
         pulse(k);
         if (k == 2)
            cnt_e = 16'h0;
         chk_all();
      end
      stop_test();
   end
endmodule : testbench
`default_nettype wire
